// *** dbs_adapter.v ***
// dynamic bus sizing adapter: 32-bit master port to one slave port
// assumes master and slave share core_clk_in; mode straps are async pins
`timescale 1ns/1ps
`default_nettype none
`include "dbs_map.vh"
module dbs_adapter #(
  parameter SW = `MAP_SLAVE_W_DEFAULT
) (
  input  wire                     core_clk_in,
  input  wire                     reset_in,
  input  wire                     clk_en_in,
  input  wire                     native_mode_in,
  input  wire                     tristate_mode_in,
  input  wire [`MAP_ADDR_W-1:0]   m_address_in,
  input  wire                     m_read_in,
  input  wire                     m_write_in,
  input  wire [`MAP_MASTER_W-1:0] m_writedata_in,
  input  wire [3:0]               m_byteenable_in,
  output reg                      m_waitrequest_out,
  output reg  [`MAP_MASTER_W-1:0] m_readdata_out,
  output reg                      m_readdatavalid_out,
  output reg  [`MAP_ADDR_W-1:0]   s_address_out,
  output reg                      s_read_out,
  output reg                      s_write_out,
  output reg  [SW-1:0]            s_writedata_out,
  output reg  [SW/8-1:0]          s_byteenable_out,
  input  wire                     s_waitrequest_in,
  input  wire [SW-1:0]            s_readdata_in,
  input  wire                     s_readdatavalid_in
);
  // integer log2 of the slave byte lane count
  function integer log2_of;
    input integer v;
    integer i;
    begin
      log2_of = 0;
      for (i = 1; i < v; i = i * 2) begin
        log2_of = log2_of + 1;
      end
    end
  endfunction

  localparam SB   = SW / 8;
  localparam SLSB = log2_of(SB);
  localparam integer NBEATS_INT =
    (SW < `MAP_MASTER_W) ? (`MAP_MASTER_W / SW) : 1;
  localparam [`MAP_BEAT_W-1:0] NBEATS_NARROW = NBEATS_INT[`MAP_BEAT_W-1:0];

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_ISSUE = 5'h02;
  localparam [4:0] ST_REQ   = 5'h04;
  localparam [4:0] ST_RESP  = 5'h08;
  localparam [4:0] ST_DONE  = 5'h10;

  ////////////////////////////////////////////////////////////////////////
  // mode strap synchronisers
  // straps are read once per request, so a change waits for idle

  reg [1:0] native_sync;
  reg [1:0] tri_sync;

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      native_sync <= 2'h0;
      tri_sync    <= 2'h0;
    end else if (clk_en_in) begin
      native_sync <= {native_sync[0], native_mode_in};
      tri_sync    <= {tri_sync[0], tristate_mode_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request latch and lane steering

  reg [4:0]               state;
  reg [`MAP_BEAT_W-1:0]   beat;
  reg [`MAP_BEAT_W-1:0]   nbeats;
  reg [`MAP_ADDR_W-1:0]   req_addr;
  reg [`MAP_MASTER_W-1:0] req_wdata;
  reg [3:0]               req_be;
  reg                     req_read;
  reg                     req_native;
  reg                     req_tri;
  reg [`MAP_MASTER_W-1:0] acc;

  wire [SW-1:0]            steer_wdata;
  wire [SB-1:0]            steer_be;
  wire [`MAP_MASTER_W-1:0] steer_rword;

  dbs_lane_steer #(
    .SW (SW)
  ) u_steer (
    .addr_in   (req_addr),
    .wdata_in  (req_wdata),
    .be_in     (req_be),
    .beat_in   (beat),
    .native_in (req_native),
    .rdata_in  (s_readdata_in),
    .acc_in    (acc),
    .wdata_out (steer_wdata),
    .be_out    (steer_be),
    .rword_out (steer_rword)
  );

  // master address is word aligned; low bits only pick a lane
  reg [`MAP_ADDR_W-1:0] word_addr;
  reg [`MAP_ADDR_W-1:0] next_s_address;

  always @* begin
    if (req_native) begin
      word_addr = req_addr >> `MAP_MASTER_LSB;
    end else begin
      word_addr = (req_addr >> SLSB) + {{(`MAP_ADDR_W-`MAP_BEAT_W){1'b0}},
                  beat};
    end
    if (req_tri) begin
      // low lines stay unconnected at the tri-state device
      next_s_address = word_addr << SLSB;
    end else begin
      next_s_address = word_addr;
    end
  end

  // nbeats is at least one, so the subtraction never wraps
  wire last_beat = (beat == nbeats - 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // transfer sequencer
  // one slave access in flight; beats are not pipelined

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      state               <= ST_IDLE;
      beat                <= 3'h0;
      nbeats              <= 3'h1;
      req_addr            <= 32'h0;
      req_wdata           <= 32'h0;
      req_be              <= 4'h0;
      req_read            <= 1'b0;
      req_native          <= 1'b0;
      req_tri             <= 1'b0;
      acc                 <= 32'h0;
      m_waitrequest_out   <= 1'b1;
      m_readdata_out      <= 32'h0;
      m_readdatavalid_out <= 1'b0;
      s_address_out       <= 32'h0;
      s_read_out          <= 1'b0;
      s_write_out         <= 1'b0;
      s_writedata_out     <= {SW{1'b0}};
      s_byteenable_out    <= {SB{1'b0}};
    end else if (clk_en_in) begin
      case (state)
        ST_IDLE: begin
          // taken while waitrequest is still high; master holds it
          m_readdatavalid_out <= 1'b0;
          if (m_read_in || m_write_in) begin
            req_addr   <= m_address_in;
            req_wdata  <= m_writedata_in;
            req_be     <= m_byteenable_in;
            req_read   <= m_read_in;
            req_native <= native_sync[1];
            req_tri    <= tri_sync[1];
            nbeats     <= native_sync[1] ? 3'h1 : NBEATS_NARROW;
            beat       <= 3'h0;
            acc        <= 32'h0;
            state      <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          // beats with all enables low still go out
          s_address_out    <= next_s_address;
          s_writedata_out  <= steer_wdata;
          s_byteenable_out <= steer_be;
          s_read_out       <= req_read;
          s_write_out      <= ~req_read;
          state            <= ST_REQ;
        end
        ST_REQ: begin
          if (!s_waitrequest_in) begin
            // drop at once so the slave cannot take it twice
            s_read_out  <= 1'b0;
            s_write_out <= 1'b0;
            if (req_read) begin
              state <= ST_RESP;
            end else if (last_beat) begin
              m_waitrequest_out <= 1'b0;
              state             <= ST_DONE;
            end else begin
              beat  <= beat + 3'h1;
              state <= ST_ISSUE;
            end
          end
        end
        ST_RESP: begin
          // one slave read outstanding, so valid data is ours
          if (s_readdatavalid_in) begin
            acc <= steer_rword;
            if (last_beat) begin
              m_readdata_out      <= steer_rword;
              m_readdatavalid_out <= 1'b1;
              m_waitrequest_out   <= 1'b0;
              state               <= ST_DONE;
            end else begin
              beat  <= beat + 3'h1;
              state <= ST_ISSUE;
            end
          end
        end
        ST_DONE: begin
          // master held until every beat finished
          m_waitrequest_out   <= 1'b1;
          m_readdatavalid_out <= 1'b0;
          state               <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** dbs_map.vh ***
// constants for the dynamic bus sizing adapter
// assumes a 32-bit master and one slave port on the same clock
// Notes on behaviour
// - wide master reads narrow slave in beats
// - narrow master gets only its slave lanes
// - adapter makes slave byte enables on writes
// - slave width 8 to 1024, powers of two
// - word N maps to 2N/2N+1 or N/2
// - slave decodes its own word addresses
// - tri-state slaves receive byte addresses
// - native reads zero-pad above slave width
// - native writes drop bits above slave width
// - native: one master word per slave word
// - native 64-bit slave: upper 32 bits zero
// - native mode deprecated but still supported
// - normal sizing keeps slave data contiguous
// - read data returns to the issuing master
// - master byte address becomes slave word address
`ifndef DBS_MAP_VH
`define DBS_MAP_VH
`define MAP_MASTER_W        32
`define MAP_MASTER_BYTES    4
`define MAP_MASTER_LSB      2
`define MAP_SLAVE_W_DEFAULT 16
`define MAP_SLAVE_W_MIN     8
`define MAP_SLAVE_W_MAX     1024
`define MAP_BEAT_W          3
`define MAP_ADDR_W          32
`endif

// *** dbs_lane_steer.v ***
// byte lane steering between a 32-bit master word and one slave word
// purely combinational; the adapter holds every input but rdata_in, beat_in and acc_in stable
`timescale 1ns/1ps
`default_nettype none
`include "dbs_map.vh"
module dbs_lane_steer #(
  parameter SW = `MAP_SLAVE_W_DEFAULT
) (
  input  wire [`MAP_ADDR_W-1:0]   addr_in,
  input  wire [`MAP_MASTER_W-1:0] wdata_in,
  input  wire [3:0]               be_in,
  input  wire [`MAP_BEAT_W-1:0]   beat_in,
  input  wire                     native_in,
  input  wire [SW-1:0]            rdata_in,
  input  wire [`MAP_MASTER_W-1:0] acc_in,
  output reg  [SW-1:0]            wdata_out,
  output reg  [SW/8-1:0]          be_out,
  output reg  [`MAP_MASTER_W-1:0] rword_out
);
  localparam W  = (SW > `MAP_MASTER_W) ? SW : `MAP_MASTER_W;
  localparam WB = W / 8;
  localparam SB = SW / 8;

  reg [W-1:0]  wide;
  reg [W-1:0]  rtmp;
  reg [WB-1:0] wbe;
  integer      lane;

  always @* begin
    wide = {W{1'b0}};
    wide[`MAP_MASTER_W-1:0] = wdata_in;
    wbe = {WB{1'b0}};
    wbe[3:0] = be_in;
    rtmp = {W{1'b0}};
    rtmp[SW-1:0] = rdata_in;
    lane = (addr_in & (SB - 1)) >> `MAP_MASTER_LSB;
    if (native_in) begin
      wdata_out = wide[SW-1:0];
      be_out    = wbe[SB-1:0];
      rword_out = rtmp[`MAP_MASTER_W-1:0];
    end else if (SW < `MAP_MASTER_W) begin
      // beat 0 carries the low half, so word 2N is the low part
      wide      = wide >> (beat_in * SW);
      wbe       = wbe >> (beat_in * SB);
      wdata_out = wide[SW-1:0];
      be_out    = wbe[SB-1:0];
      rtmp      = rtmp << (beat_in * SW);
      rword_out = acc_in | rtmp[`MAP_MASTER_W-1:0];
    end else begin
      wide      = wide << (lane * `MAP_MASTER_W);
      wbe       = wbe << (lane * `MAP_MASTER_BYTES);
      wdata_out = wide[SW-1:0];
      be_out    = wbe[SB-1:0];
      rtmp      = rtmp >> (lane * `MAP_MASTER_W);
      rword_out = rtmp[`MAP_MASTER_W-1:0];
    end
  end
endmodule
`default_nettype wire

// *** dbs_slave_model.sv ***
// 16-bit slave with random wait states and read latency
// assumes one clock shared with the adapter
`timescale 1ns/1ps
`default_nettype none
module dbs_slave_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        byte_addr_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [15:0] wd_in,
  input  wire logic [1:0]  be_in,
  output logic             wait_out,
  output logic [15:0]      rd_out,
  output logic             valid_out
);
  logic [15:0] mem [0:63];
  logic [15:0] lfsr;
  logic [5:0]  idx;
  logic [5:0]  pidx;
  logic        pend;
  assign idx = byte_addr_in ? addr_in[6:1] : addr_in[5:0];
  //////////////////////////////////////////////////////////////////////
  // idle data toggles so a stale word never looks valid
  always @(posedge clk_in) begin
    lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    valid_out <= 1'b0;
    rd_out <= ~rd_out;
    wait_out <= lfsr[0];
    if (rst_in) begin
      lfsr <= 16'hace1;
      rd_out <= 16'h0;
      wait_out <= 1'b1;
      pend <= 1'b0;
      for (int i = 0; i < 64; i++)
        mem[i] <= 16'h0;
    end else if (pend && lfsr[1]) begin
      valid_out <= 1'b1;
      rd_out <= mem[pidx];
      pend <= 1'b0;
    end else if (!wait_out && rd_in) begin
      pend <= 1'b1;
      pidx <= idx;
    end
    if (!rst_in && !wait_out && wr_in && be_in[0])
      mem[idx][7:0] <= wd_in[7:0];
    if (!rst_in && !wait_out && wr_in && be_in[1])
      mem[idx][15:8] <= wd_in[15:8];
  end
endmodule
`default_nettype wire

// *** dbs_adapter_asserts.sv ***
// port checker for the bus sizing adapter
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "dbs_map.vh"
module dbs_chk #(
  parameter SW = 16
) (
  input wire logic                   core_clk_in,
  input wire logic                   reset_in,
  input wire logic                   native_mode_in,
  input wire logic                   tristate_mode_in,
  input wire logic                   m_waitrequest_out,
  input wire logic                   m_readdatavalid_out,
  input wire logic [`MAP_MASTER_W-1:0] m_readdata_out,
  input wire logic [`MAP_ADDR_W-1:0] s_address_out,
  input wire logic                   s_read_out,
  input wire logic                   s_write_out,
  input wire logic                   s_waitrequest_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence lo_take;
    (s_read_out || s_write_out) && !s_waitrequest_in && !s_address_out[0]
      && !native_mode_in && !tristate_mode_in;
  endsequence
  sequence hi_req;
    (s_read_out || s_write_out) && s_address_out[0];
  endsequence
  a_reset_idle: assert property ($fell(reset_in) |-> m_waitrequest_out
    && !s_read_out && !s_write_out) else $error("busy after reset");
  a_wait_one_cycle: assert property (!m_waitrequest_out
    |=> m_waitrequest_out) else $error("wait low too long");
  a_valid_with_wait: assert property (m_readdatavalid_out
    |-> !m_waitrequest_out) else $error("valid without accept");
  a_beat_order: assert property (lo_take
    |=> m_waitrequest_out ##[1:40] hi_req) else $error("no upper beat");
  a_native_pad: assert property (m_readdatavalid_out && native_mode_in
    |-> m_readdata_out[31:16] == 16'h0) else $error("upper bits not zero");
  a_tri_byte_addr: assert property (tristate_mode_in
    && (s_read_out || s_write_out) |-> !s_address_out[0])
    else $error("odd byte address");
  a_slave_hold: assert property (s_read_out && s_waitrequest_in
    |=> s_read_out && $stable(s_address_out)) else $error("request moved");
  a_drop_after_take: assert property ((s_read_out || s_write_out)
    && !s_waitrequest_in |=> !s_read_out && !s_write_out)
    else $error("request held after accept");
endmodule
bind dbs_adapter dbs_chk #(.SW(SW)) u_chk (
  .core_clk_in(core_clk_in), .reset_in(reset_in),
  .native_mode_in(native_mode_in), .tristate_mode_in(tristate_mode_in),
  .m_waitrequest_out(m_waitrequest_out),
  .m_readdatavalid_out(m_readdatavalid_out),
  .m_readdata_out(m_readdata_out), .s_address_out(s_address_out),
  .s_read_out(s_read_out), .s_write_out(s_write_out),
  .s_waitrequest_in(s_waitrequest_in));
`default_nettype wire

// *** tb_top.sv ***
// random traffic in normal, native and byte-address modes
// assumes a 16-bit slave model behind the adapter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [31:0] a_rnd = 32'h0;
  logic        native = 1'b0;
  logic        tri_m = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'h0;
  logic [31:0] seed = 32'h42f1;
  logic [15:0] sh [0:63];
  logic [31:0] exp_q [$];
  int          errors = 0;
  int          compares = 0;
  wire logic        m_wait, m_rvalid, s_rd, s_wr, s_wait, s_rvalid;
  wire logic [31:0] m_rdata, s_addr;
  wire logic [15:0] s_wd, s_rdata;
  wire logic [1:0]  s_be;
  dbs_adapter #(.SW(16)) DUT (.core_clk_in(clk), .reset_in(rst),
    .clk_en_in(ce), .native_mode_in(native), .tristate_mode_in(tri_m),
    .m_address_in(addr), .m_read_in(rd), .m_write_in(wr),
    .m_writedata_in(wdata), .m_byteenable_in(be),
    .m_waitrequest_out(m_wait), .m_readdata_out(m_rdata),
    .m_readdatavalid_out(m_rvalid), .s_address_out(s_addr),
    .s_read_out(s_rd), .s_write_out(s_wr), .s_writedata_out(s_wd),
    .s_byteenable_out(s_be), .s_waitrequest_in(s_wait),
    .s_readdata_in(s_rdata), .s_readdatavalid_in(s_rvalid));
  dbs_slave_model u_slave (.clk_in(clk), .rst_in(rst), .byte_addr_in(tri_m),
    .rd_in(s_rd), .wr_in(s_wr), .addr_in(s_addr), .wd_in(s_wd),
    .be_in(s_be), .wait_out(s_wait), .rd_out(s_rdata),
    .valid_out(s_rvalid));
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task conclude;
    if (exp_q.size() != 0)
      errors++;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // request held back to back; the accept edge or the 200-cycle timeout ends it
  task automatic op(input logic w, input logic [31:0] a,
                    input logic [31:0] d, input logic [3:0] b);
    int k;
    int n;
    logic [31:0] e;
    k = native ? a[7:2] : a[6:1];
    for (n = 0; n < 4; n++)
      if (w && b[n] && (!native || n < 2))
        sh[k + n / 2][8 * (n % 2) +: 8] = d[8 * n +: 8];
    e = native ? {16'h0, sh[k]} : {sh[k + 1], sh[k]};
    if (!w)
      exp_q.push_back(e);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    // frozen adapter must keep the master waiting and the slave read strobe low
    if (seed[15]) begin
      ce <= 1'b0;
      repeat (2) begin
        @(posedge clk);
        compares++;
        if (m_wait !== 1'b1 || s_rd !== 1'b0) begin
          errors++;
          $display("[ERR] %0t got %h exp %h", $time, {m_wait, s_rd}, 2'h2);
        end
      end
      ce <= 1'b1;
    end
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (m_wait === 1'b0) break;
    end
    if (n == 200) begin
      errors++;
      conclude();
    end
  endtask
  always @(posedge clk) begin
    if (m_rvalid === 1'b1) begin
      compares++;
      if (exp_q.size() == 0) begin
        errors++;
        $display("[ERR] %0t got %h exp %h", $time, m_rdata, 32'h0);
      end else begin
        if (m_rdata !== exp_q[0]) begin
          errors++;
          $display("[ERR] %0t got %h exp %h", $time, m_rdata, exp_q[0]);
        end
        void'(exp_q.pop_front());
      end
    end
  end
  initial begin
    for (int i = 0; i < 64; i++)
      sh[i] = 16'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // aligned addresses only, random byte enable patterns from seed[11:8]
    // mode 3 is native addressing behind a byte-addressed slave
    for (int m = 0; m < 4; m++) begin
      native <= (m == 1 || m == 3);
      tri_m <= (m >= 2);
      repeat (4) @(posedge clk);
      for (int i = 0; i < 60; i++) begin
        seed = xs(seed);
        a_rnd = seed & (native ? 32'hfc : 32'h7c);
        op(seed[31], a_rnd, xs(seed), seed[11:8]);
      end
      rd <= 1'b0;
      wr <= 1'b0;
    end
    repeat (20) @(posedge clk);
    conclude();
  end
endmodule
`default_nettype wire
